// ==== pkg/scsp_defines.vh ====
/*
 * Constants for the clock-stop serial port: word and FIFO geometry,
 * clock-stop mode codes, counter widths and forced slave rate settings.
 * Assumes inclusion by bare name from design files.
 */
`ifndef SCSP_DEFINES_VH
`define SCSP_DEFINES_VH

// Word and buffer geometry
`define SCSP_WORD_W 16
`define SCSP_BITCNT_W 5
`define SCSP_FIFO_DEPTH 8
`define SCSP_FIFO_AW 3

// Rate generator divider and phase counter widths
`define SCSP_DIV_W 8
`define SCSP_CNT_W 9

// Clock-stop mode codes: no delay (edge launch) and half-cycle delay
`define SCSP_STOP_NODLY 2'h2
`define SCSP_STOP_HALF 2'h3

// Forced rate generator settings in slave mode (half the CPU clock)
`define SCSP_SLV_SRC_SEL 1'h1
`define SCSP_SLV_DIVIDER 8'h01

// Master sequencer states
`define SCSP_ST_IDLE 2'h0
`define SCSP_ST_LEAD 2'h1
`define SCSP_ST_SHIFT 2'h2
`define SCSP_ST_TRAIL 2'h3

`endif

// ==== design/scsp_fifo.v ====
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock, an active-low asynchronous reset and a clock enable
 * that freezes all state while low.
 */
`timescale 1ns/100ps
module scsp_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    input wire clk_en,
    // Fill side
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    // Drain side
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    // Honest full and empty from the occupancy count
    assign in_ready = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_r];
    assign push = clk_en & in_valid & in_ready;
    assign pop = clk_en & out_valid & out_ready;

    // Storage array write
    always @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // Pointers and count
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push & ~pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop & ~push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

// ==== design/scsp_core.v ====
/*
 * Clock-stop serial port (SPI style), master or slave, clock polarity 0.
 * Holds the rate divider, master sequencer, slave edge tracker, shifters
 * and a transmit FIFO. Assumes all pins synchronous to mclk, the CPU clock.
 */
// Functional notes
// - In slave mode the rate generator runs at half CPU clock, select and divider 1.
// - Generated serial clock period is (1 + divider) times 2H, or 2 times 2H for divider 0.
// - Low phase is half period for odd or zero divider, divider/2 times 2H if even.
// - High phase is half period for odd or zero divider, divider/2+1 times 2H if even.
// - Master with frame polarity 1 inverts transmit frame into active-low slave enable.
// - Slave inverts active-low enables on transmit and receive frame pins before use.
// - Master: transmit clock and frame directions 1, receive directions 0.
// - Slave: all four clock and frame directions are 0, driven from outside.
// - Master asserts slave enable before the rising clock edge that starts the transfer.
// - Port timing follows CPU clock only, independent of bus clock divide factor.
// - Master first rising edge follows enable by low width (10b) or full period (11b).
// - Master holds enable after last falling edge a full period (10b) or low width (11b).
// - Mode 10b: data launched after rising edge, sampled on falling edge.
// - Mode 11b: data launched after falling edge, sampled on rising edge.
// - Master output floats low width after last falling edge (10b), immediately (11b).
// - Slave output floats after last bit once the slave enable is released.
`timescale 1ns/100ps
`include "scsp_defines.vh"
module scsp_core (
    // Clock, reset and clock enable
    input wire mclk,
    input wire rst_n,
    input wire clk_en,
    // Configuration
    input wire master_mode,
    input wire [1:0] clock_stop_select,
    input wire [`SCSP_DIV_W-1:0] rate_gen_divider,
    input wire tx_frame_polarity,
    input wire rx_frame_polarity,
    // Effective settings and status
    output wire tx_clock_direction,
    output wire rx_clock_direction,
    output wire tx_frame_direction,
    output wire rx_frame_direction,
    output wire rate_gen_source_sel,
    output wire [`SCSP_DIV_W-1:0] rate_gen_divider_eff,
    output wire busy,
    // Transmit word stream
    input wire [`SCSP_WORD_W-1:0] tx_data,
    input wire tx_valid,
    output wire tx_ready,
    // Receive word stream
    output reg [`SCSP_WORD_W-1:0] rx_data,
    output reg rx_valid,
    // Serial clock pin
    input wire tx_serial_clock_pin_i,
    output wire tx_serial_clock_pin_o,
    output wire tx_serial_clock_pin_oe,
    // Frame sync pins
    input wire tx_frame_sync_pin_i,
    output wire tx_frame_sync_pin_o,
    output wire tx_frame_sync_pin_oe,
    input wire rx_frame_sync_pin,
    // Serial data pins
    output wire serial_data_out_o,
    output wire serial_data_out_oe,
    input wire serial_data_in
);
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [`SCSP_CNT_W-1:0] cnt_r;
    reg [`SCSP_CNT_W-1:0] cnt_nxt;
    reg sck_r;
    reg sck_nxt;
    reg [`SCSP_BITCNT_W-1:0] bits_r;
    reg [`SCSP_BITCNT_W-1:0] bits_nxt;
    reg fs_act_r;
    reg fs_act_nxt;
    reg oe_r;
    reg oe_nxt;
    reg [`SCSP_WORD_W-1:0] tsr_r;
    reg [`SCSP_WORD_W-1:0] rsr_r;
    reg [`SCSP_BITCNT_W-1:0] rbits_r;
    reg rg_tick_r;
    reg s_sck_r;
    reg s_act_r;
    reg s_first_r;
    wire [`SCSP_WORD_W-1:0] fifo_data;
    wire fifo_valid;
    wire fifo_pop;
    wire mode_half;
    wire [`SCSP_CNT_W-1:0] low_w;
    wire [`SCSP_CNT_W-1:0] high_w;
    wire [`SCSP_CNT_W-1:0] per_w;
    wire s_se_tx;
    wire s_se_rx;
    wire s_rise;
    wire s_fall;
    wire m_rise;
    wire m_fall;
    wire launch;
    wire sample;
    wire load;
    wire rx_act;

    // Phase width in mclk cycles; one mclk cycle is 2H
    function [`SCSP_CNT_W-1:0] phase_w;
        input [`SCSP_DIV_W-1:0] div;
        input high;
        begin
            if (div == {`SCSP_DIV_W{1'b0}}) begin
                phase_w = {{(`SCSP_CNT_W-1){1'b0}}, 1'b1};
            end else if (div[0]) begin
                phase_w = ({1'b0, div} + 1'b1) >> 1; // Odd: half period
            end else begin
                phase_w = ({1'b0, div} >> 1) + {{(`SCSP_CNT_W-1){1'b0}}, high};
            end
        end
    endfunction

    assign mode_half = (clock_stop_select == `SCSP_STOP_HALF);
    assign low_w = phase_w(rate_gen_divider_eff, 1'b0);
    assign high_w = phase_w(rate_gen_divider_eff, 1'b1);
    assign per_w = low_w + high_w;

    // Direction settings and effective rate generator setup
    assign tx_clock_direction = master_mode;
    assign tx_frame_direction = master_mode;
    assign rx_clock_direction = 1'b0;
    assign rx_frame_direction = 1'b0;
    assign rate_gen_source_sel = master_mode ? 1'b0 : `SCSP_SLV_SRC_SEL;
    assign rate_gen_divider_eff = master_mode ? rate_gen_divider : `SCSP_SLV_DIVIDER;

    // Pin drive: clock idles low, frame inverted to active-low enable
    assign tx_serial_clock_pin_o = master_mode & sck_r;
    assign tx_serial_clock_pin_oe = tx_clock_direction;
    assign tx_frame_sync_pin_o = tx_frame_polarity ? ~fs_act_r : fs_act_r;
    assign tx_frame_sync_pin_oe = tx_frame_direction;
    assign serial_data_out_o = tsr_r[`SCSP_WORD_W-1];
    assign serial_data_out_oe = oe_r;
    assign busy = master_mode ? (state_r != `SCSP_ST_IDLE) : s_act_r;

    // Transmit buffer
    scsp_fifo #(
        .WIDTH(`SCSP_WORD_W),
        .DEPTH(`SCSP_FIFO_DEPTH),
        .AW(`SCSP_FIFO_AW)
    ) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // Slave view: active-low enables inverted before use
    assign s_se_tx = rx_frame_polarity ? ~tx_frame_sync_pin_i : tx_frame_sync_pin_i;
    assign s_se_rx = rx_frame_polarity ? ~rx_frame_sync_pin : rx_frame_sync_pin;
    assign s_rise = rg_tick_r & s_act_r & ~s_sck_r & tx_serial_clock_pin_i;
    assign s_fall = rg_tick_r & s_act_r & s_sck_r & ~tx_serial_clock_pin_i;

    // Master edges are the cycles in which sck_r is about to change
    assign m_rise = (state_nxt == `SCSP_ST_SHIFT) & sck_nxt & ~sck_r;
    assign m_fall = (state_r == `SCSP_ST_SHIFT) & ~sck_nxt & sck_r;

    // Launch and sample edges by clock-stop mode
    assign launch = master_mode ?
        (mode_half ? (m_fall & (state_nxt == `SCSP_ST_SHIFT))
                   : (m_rise & (state_r == `SCSP_ST_SHIFT))) :
        (mode_half ? s_fall : (s_rise & ~s_first_r));
    assign sample = master_mode ? (mode_half ? m_rise : m_fall) :
        (mode_half ? s_rise : s_fall);
    assign rx_act = master_mode ? (state_r != `SCSP_ST_IDLE) : s_se_rx;

    // Word load at frame start
    assign load = master_mode ? ((state_r == `SCSP_ST_IDLE) & fifo_valid) :
        (rg_tick_r & ~s_act_r & s_se_tx);
    assign fifo_pop = load & fifo_valid;

    // Master sequencer next state
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sck_nxt = sck_r;
        bits_nxt = bits_r;
        fs_act_nxt = fs_act_r;
        oe_nxt = oe_r;
        case (state_r)
            `SCSP_ST_IDLE: begin
                sck_nxt = 1'b0;
                if (master_mode & fifo_valid) begin
                    // Enable first, clock waits low width or a period
                    state_nxt = `SCSP_ST_LEAD;
                    cnt_nxt = mode_half ? per_w : low_w;
                    fs_act_nxt = 1'b1;
                    oe_nxt = 1'b1;
                    bits_nxt = {`SCSP_BITCNT_W{1'b0}};
                end
            end
            `SCSP_ST_LEAD: begin
                if (cnt_r <= {{(`SCSP_CNT_W-1){1'b0}}, 1'b1}) begin
                    state_nxt = `SCSP_ST_SHIFT; // Transfer starts on rising edge
                    sck_nxt = 1'b1;
                    cnt_nxt = high_w;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            `SCSP_ST_SHIFT: begin
                if (cnt_r > {{(`SCSP_CNT_W-1){1'b0}}, 1'b1}) begin
                    cnt_nxt = cnt_r - 1'b1;
                end else if (sck_r) begin
                    sck_nxt = 1'b0;
                    if (bits_r == `SCSP_WORD_W - 1) begin
                        // Trailing hold of enable after last falling edge
                        state_nxt = `SCSP_ST_TRAIL;
                        cnt_nxt = mode_half ? low_w : per_w;
                        oe_nxt = ~mode_half; // Float at once in 11b
                    end else begin
                        cnt_nxt = low_w;
                        bits_nxt = bits_r + 1'b1;
                    end
                end else begin
                    sck_nxt = 1'b1;
                    cnt_nxt = high_w;
                end
            end
            `SCSP_ST_TRAIL: begin
                // Float after one low width in 10b
                if (cnt_r == per_w - low_w + 1'b1) begin
                    oe_nxt = 1'b0;
                end
                if (cnt_r <= {{(`SCSP_CNT_W-1){1'b0}}, 1'b1}) begin
                    state_nxt = `SCSP_ST_IDLE;
                    fs_act_nxt = 1'b0;
                    oe_nxt = 1'b0;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: begin
                state_nxt = `SCSP_ST_IDLE;
                sck_nxt = 1'b0;
                fs_act_nxt = 1'b0;
                oe_nxt = 1'b0;
            end
        endcase
        if (!master_mode) begin
            // Slave drives data only while its enable is held
            state_nxt = `SCSP_ST_IDLE;
            sck_nxt = 1'b0;
            fs_act_nxt = 1'b0;
            oe_nxt = s_act_r & s_se_tx | load;
        end
    end

    // Master sequencer registers
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= `SCSP_ST_IDLE;
            cnt_r <= {`SCSP_CNT_W{1'b0}};
            sck_r <= 1'b0;
            bits_r <= {`SCSP_BITCNT_W{1'b0}};
            fs_act_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sck_r <= sck_nxt;
            bits_r <= bits_nxt;
            fs_act_r <= fs_act_nxt;
            oe_r <= oe_nxt;
        end
    end

    // Slave rate tick at half the CPU clock, pin edge tracking
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rg_tick_r <= 1'b0;
            s_sck_r <= 1'b0;
            s_act_r <= 1'b0;
            s_first_r <= 1'b0;
        end else if (clk_en) begin
            rg_tick_r <= ~rg_tick_r;
            if (master_mode) begin
                s_act_r <= 1'b0;
            end else if (rg_tick_r) begin
                s_sck_r <= tx_serial_clock_pin_i;
                s_act_r <= s_se_tx;
                if (load) begin
                    s_first_r <= 1'b1;
                end else if (s_rise) begin
                    s_first_r <= 1'b0;
                end
            end
        end
    end

    // Transmit shifter: MSB first, zeros sent when buffer underruns
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tsr_r <= {`SCSP_WORD_W{1'b0}};
        end else if (clk_en) begin
            if (load) begin
                tsr_r <= fifo_valid ? fifo_data : {`SCSP_WORD_W{1'b0}};
            end else if (launch) begin
                tsr_r <= {tsr_r[`SCSP_WORD_W-2:0], 1'b0};
            end
        end
    end

    // Receive shifter and word delivery
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rsr_r <= {`SCSP_WORD_W{1'b0}};
            rbits_r <= {`SCSP_BITCNT_W{1'b0}};
            rx_data <= {`SCSP_WORD_W{1'b0}};
            rx_valid <= 1'b0;
        end else if (clk_en) begin
            rx_valid <= 1'b0;
            if (!rx_act) begin
                rbits_r <= {`SCSP_BITCNT_W{1'b0}};
            end else if (sample) begin
                rsr_r <= {rsr_r[`SCSP_WORD_W-2:0], serial_data_in};
                if (rbits_r == `SCSP_WORD_W - 1) begin
                    rbits_r <= {`SCSP_BITCNT_W{1'b0}};
                    rx_data <= {rsr_r[`SCSP_WORD_W-2:0], serial_data_in};
                    rx_valid <= 1'b1;
                end else begin
                    rbits_r <= rbits_r + 1'b1;
                end
            end
        end
    end
endmodule

// ==== tb/scsp_core_monitor.sv ====
/* Port checker for scsp_core, bound onto every instance.
   Assumes clk_en held high and settings changed only while idle. */
`timescale 1ns/100ps
module scsp_core_monitor (
    // Clock, reset and settings
    input wire mclk,
    input wire rst_n,
    input wire master_mode,
    input wire [1:0] clock_stop_select,
    input wire [7:0] rate_gen_divider,
    input wire tx_frame_polarity,
    input wire rx_frame_polarity,
    // Status and pins
    input wire busy,
    input wire tx_serial_clock_pin_o,
    input wire tx_frame_sync_pin_i,
    input wire tx_frame_sync_pin_o,
    input wire serial_data_out_o,
    input wire serial_data_out_oe
);
    wire sck = tx_serial_clock_pin_o;
    wire act = tx_frame_sync_pin_o ^ tx_frame_polarity;
    wire m11 = clock_stop_select == 2'h3;
    wire [8:0] dv = {1'b0, rate_gen_divider};
    // Expected low, high and full phase lengths in cycles
    wire [8:0] lw = (dv == 9'h000) ? 9'h001 : (dv + {8'h00, dv[0]}) >> 1;
    wire [8:0] hw = (dv == 9'h000 || dv[0]) ? lw : lw + 9'h001;
    wire [8:0] per = lw + hw;
    reg sck_q;
    reg [8:0] run_r;
    reg [8:0] age_r;
    reg [8:0] tail_r;
    reg [4:0] nr_r;
    wire rise = sck & ~sck_q;
    wire fall = ~sck & sck_q;
    // Phase length, frame age, rise count and age since the last fall
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sck_q <= 1'b0;
            run_r <= 9'h000;
            age_r <= 9'h000;
            tail_r <= 9'h000;
            nr_r <= 5'h00;
        end else begin
            sck_q <= sck;
            run_r <= (sck != sck_q) ? 9'h001 : run_r + 9'h001;
            age_r <= act ? age_r + 9'h001 : 9'h000;
            nr_r <= act ? nr_r + {4'h0, rise} : 5'h00;
            tail_r <= (fall && nr_r == 5'h10) ? 9'h001 :
                (act && tail_r != 9'h000) ? tail_r + 9'h001 : 9'h000;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Steps of a word: its last fall, a held and a released slave enable
    sequence last_fall;
        fall && nr_r == 5'h10;
    endsequence
    sequence slave_on;
        (tx_frame_sync_pin_i != rx_frame_polarity) [*4];
    endsequence
    sequence slave_off;
        (tx_frame_sync_pin_i == rx_frame_polarity) [*6];
    endsequence
    low_phase_a: assert property (
        master_mode && rise && nr_r != 5'h00 |-> run_r == lw) else $error("low phase length");
    high_phase_a: assert property (
        master_mode && fall |-> run_r == hw) else $error("high phase length");
    first_rise_a: assert property (
        master_mode && rise && nr_r == 5'h00 |-> act && age_r == (m11 ? per : lw))
        else $error("first rise timing");
    enable_hold_a: assert property (
        master_mode && $fell(act) |-> tail_r == (m11 ? lw : per)) else $error("enable hold");
    data_float_a: assert property (
        master_mode && $fell(serial_data_out_oe) |-> if (m11) last_fall else (tail_r == lw))
        else $error("data float timing");
    launch_rise_a: assert property (
        master_mode && !m11 && serial_data_out_oe && $past(serial_data_out_oe)
        && $changed(serial_data_out_o) |-> rise) else $error("data moved off rise");
    launch_fall_a: assert property (
        master_mode && m11 && serial_data_out_oe && $past(serial_data_out_oe)
        && $changed(serial_data_out_o) |-> fall) else $error("data moved off fall");
    clock_idle_a: assert property (
        master_mode && !act |-> !sck) else $error("clock toggles outside frame");
    frame_idle_a: assert property (
        master_mode && !busy |-> tx_frame_sync_pin_o == tx_frame_polarity)
        else $error("idle enable level");
    slave_select_a: assert property (
        !master_mode ##0 slave_on |-> busy) else $error("slave enable not seen");
    slave_float_a: assert property (
        !master_mode ##0 slave_off |-> !serial_data_out_oe) else $error("slave data driven");
endmodule
bind scsp_core scsp_core_monitor scsp_core_monitor_inst (.mclk, .rst_n, .master_mode,
    .clock_stop_select, .rate_gen_divider, .tx_frame_polarity, .rx_frame_polarity, .busy,
    .tx_serial_clock_pin_o, .tx_frame_sync_pin_i, .tx_frame_sync_pin_o, .serial_data_out_o,
    .serial_data_out_oe);

// ==== tb/scsp_far_model.sv ====
/* Far-side SPI party: slave while the core is master, master otherwise.
   Assumes pins synchronous to mclk and an active-low enable. */
`timescale 1ns/100ps
module scsp_far_model (
    // Clock and control
    input wire mclk,
    input wire mode11,
    input wire go,
    input wire [15:0] far_word,
    output reg [15:0] far_rx,
    // Wire levels and own drivers
    input wire sck_w,
    input wire sel_w,
    input wire serial_data_out_o,
    input wire serial_data_out_oe,
    output reg far_sck = 1'b0,
    output reg far_sel_n = 1'b1,
    output wire far_dout
);
    reg sck_q = 1'b0;
    reg idle_r = 1'b0;
    reg first_r = 1'b1;
    reg [15:0] sh_r = 16'h0000;
    wire rise = sck_w & ~sck_q;
    wire fall = ~sck_w & sck_q;
    // Released data line toggles so no stale bit can be read
    assign far_dout = sel_w ? idle_r : sh_r[15];
    // Shift after the launch edge, capture on the sampling edge
    always @(posedge mclk) begin
        sck_q <= sck_w;
        idle_r <= ~idle_r;
        if (sel_w) begin
            sh_r <= far_word;
            first_r <= 1'b1;
        end else begin
            if (rise) first_r <= 1'b0;
            if (mode11 ? rise : fall)
                far_rx <= {far_rx[14:0], serial_data_out_oe ? serial_data_out_o : 1'bx};
            if (mode11 ? fall : rise & ~first_r)
                sh_r <= {sh_r[14:0], 1'b0};
        end
    end
    // Master role: enable first, 16 pulses of four-cycle phases, release
    always begin
        @(posedge mclk);
        if (go) begin
            far_sel_n <= 1'b0;
            repeat (4) @(posedge mclk);
            repeat (32) begin
                far_sck <= ~far_sck;
                repeat (4) @(posedge mclk);
            end
            far_sel_n <= 1'b1;
            repeat (4) @(posedge mclk);
        end
    end
endmodule

// ==== tb/testbench.sv ====
/* Self-checking bench for scsp_core with the far-side model.
   Assumes clk_en high except during the slave fill test, and the defines header on the include path. */
`timescale 1ns/100ps
`include "scsp_defines.vh"
module testbench;
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg clk_en = 1'b1;
    reg master_mode = 1'b1;
    reg [1:0] clock_stop_select = `SCSP_STOP_NODLY;
    reg [7:0] rate_gen_divider = 8'h05;
    reg tx_frame_polarity = 1'b1;
    reg [15:0] tx_data = 16'h0000;
    reg tx_valid = 1'b0;
    reg go = 1'b0;
    reg [15:0] far_word = 16'h0000;
    reg [15:0] last_rx = 16'h0000;
    reg [15:0] words [0:7];
    integer nrx = 0, cyc = 0, n_errors = 0, checks = 0, i;
    wire [15:0] far_rx, rx_data;
    wire [7:0] rate_gen_divider_eff;
    wire tx_clock_direction, rx_clock_direction, tx_frame_direction, rx_frame_direction;
    wire rate_gen_source_sel, busy, tx_ready, rx_valid, far_sck, far_sel_n, far_dout;
    wire tx_serial_clock_pin_o, tx_serial_clock_pin_oe, tx_frame_sync_pin_o;
    wire tx_frame_sync_pin_oe, serial_data_out_o, serial_data_out_oe;
    // Wire levels resolved from both parties' enables
    wire sck_w = tx_serial_clock_pin_oe ? tx_serial_clock_pin_o : far_sck;
    wire sel_w = tx_frame_sync_pin_oe ? tx_frame_sync_pin_o : far_sel_n;
    wire tx_serial_clock_pin_i = sck_w;
    wire tx_frame_sync_pin_i = sel_w;
    wire rx_frame_sync_pin = sel_w;
    wire serial_data_in = far_dout;
    wire rx_frame_polarity = tx_frame_polarity;
    wire mode11 = clock_stop_select == `SCSP_STOP_HALF;
    scsp_core scsp_core_inst (.mclk, .rst_n, .clk_en, .master_mode, .clock_stop_select,
        .rate_gen_divider, .tx_frame_polarity, .rx_frame_polarity, .tx_clock_direction,
        .rx_clock_direction, .tx_frame_direction, .rx_frame_direction, .rate_gen_source_sel,
        .rate_gen_divider_eff, .busy, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid,
        .tx_serial_clock_pin_i, .tx_serial_clock_pin_o, .tx_serial_clock_pin_oe,
        .tx_frame_sync_pin_i, .tx_frame_sync_pin_o, .tx_frame_sync_pin_oe, .rx_frame_sync_pin,
        .serial_data_out_o, .serial_data_out_oe, .serial_data_in);
    scsp_far_model scsp_far_model_inst (.mclk, .mode11, .go, .far_word, .far_rx, .sck_w,
        .sel_w, .serial_data_out_o, .serial_data_out_oe, .far_sck, .far_sel_n, .far_dout);
    // Clock of 25 ns
    initial forever #12.5 mclk = ~mclk;
    // Received words, and a ceiling on run length
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (rx_valid === 1'b1) begin
            last_rx <= rx_data;
            nrx <= nrx + 1;
        end
        if (cyc > 30000) begin
            n_errors = n_errors + 1;
            report_and_stop;
        end
    end
    task check(input [15:0] got, input [15:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            n_errors = n_errors + 1;
        end
    endtask
    task push(input [15:0] w);
        tx_data <= w;
        tx_valid <= 1'b1;
        @(posedge mclk);
    endtask
    // One word each way; w is what the far side must receive
    task xfer(input [15:0] p, input [15:0] w);
        integer k, n0;
        n0 = nrx;
        far_word <= p;
        if (master_mode) begin
            push(w);
        end else begin
            go <= 1'b1;
            @(posedge mclk);
        end
        tx_valid <= 1'b0;
        go <= 1'b0;
        for (k = 0; k < 2000 && (nrx == n0 || busy !== 1'b0 || sel_w !== 1'b1); k = k + 1)
            @(posedge mclk);
        check(k < 2000, 1'b1);
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check(last_rx, p);
        check(far_rx, w);
        check(serial_data_out_oe, 1'b0);
        @(posedge mclk);
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        for (i = 0; i < 8; i = i + 1) words[i] = 16'h8001 ^ (16'h1357 * i[15:0]);
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        check(tx_ready, 1'b1);
        check(tx_serial_clock_pin_o, 1'b0);
        check(tx_frame_sync_pin_o, 1'b1);
        check({tx_clock_direction, tx_frame_direction, rx_clock_direction,
            rx_frame_direction}, 4'hC);
        @(posedge mclk);
        tx_frame_polarity <= 1'b0;
        @(negedge mclk);
        check(tx_frame_sync_pin_o, 1'b0);
        @(posedge mclk);
        tx_frame_polarity <= 1'b1;
        // Master words in both stop modes, odd and even dividers
        for (i = 0; i < 4; i = i + 1) begin
            clock_stop_select <= i[1] ? `SCSP_STOP_HALF : `SCSP_STOP_NODLY;
            rate_gen_divider <= i[0] ? 8'h06 : 8'h05;
            @(posedge mclk);
            xfer(~words[i], words[i]);
        end
        // Slave: fill the buffer until it refuses, then drain it
        master_mode <= 1'b0;
        @(posedge mclk);
        for (i = 0; i < 7; i = i + 1) push(words[i]);
        // Clock enable low: the last word must not be taken
        clk_en <= 1'b0;
        push(words[7]);
        @(negedge mclk);
        check(tx_ready, 1'b1);
        @(posedge mclk);
        clk_en <= 1'b1;
        @(posedge mclk);
        tx_valid <= 1'b0;
        @(negedge mclk);
        check(tx_ready, 1'b0);
        check({tx_clock_direction, tx_frame_direction, rate_gen_source_sel}, 3'h1);
        check(rate_gen_divider_eff, `SCSP_SLV_DIVIDER);
        @(posedge mclk);
        for (i = 0; i < 8; i = i + 1) begin
            clock_stop_select <= i[0] ? `SCSP_STOP_HALF : `SCSP_STOP_NODLY;
            xfer(16'h0F0F ^ words[i], words[i]);
        end
        xfer(16'hBEEF, 16'h0000);
        @(negedge mclk);
        check(tx_ready, 1'b1);
        report_and_stop;
    end
endmodule
